// file: src/ptc_core.sv
/*
 * on-delay timer coils, down-counter coils and digital i/o of a ladder controller.
 * assumes scan_i pulses once per ladder scan with coil vectors valid in that cycle;
 * program writes are single-cycle pulses on the shared index and value ports.
 */
// Functional notes
// RULE_01 - timer contact open until preset elapses
// RULE_02 - contact closed while coil stays energised
// RULE_03 - coil off opens contacts at once
// RULE_04 - early drop resets timer, no closure
// RULE_05 - re-energise restarts from full preset
// RULE_06 - first counter energise loads preset minus one
// RULE_07 - decrement only on coil off-to-on
// RULE_08 - zero count latches counter contacts on
// RULE_09 - clear function alone turns contacts off
// RULE_10 - output word bit n drives output n+1
// RULE_11 - input word two bit one is input 10
// RULE_12 - invert flips the named output
// RULE_13 - custom function runs only when rung active
// RULE_14 - timer values count tenths of seconds
// RULE_15 - 64 timers, 64 counters, readable writable values
// RULE_16 - edges found against previous scan state
// RULE_17 - clear re-arms counter for reload
`timescale 1ns/10ps
module ptc_core #(
   parameter int unsigned TICK_CYCLES = ptc_pkg::PV_UNIT_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic scan_i,
   input wire logic [63:0] tmr_coil_i,
   input wire logic [63:0] ctr_coil_i,
   input wire logic [63:0] counter_clear_function_i,
   input wire logic [5:0] idx_i,
   input wire logic [15:0] val_i,
   input wire logic tmr_preset_we_i,
   input wire logic ctr_preset_we_i,
   input wire logic tmr_pv_we_i,
   input wire logic ctr_pv_we_i,
   input wire logic [5:0] rd_idx_i,
   input wire logic cusfn_coil_i,
   input wire logic bit_set_op_i,
   input wire logic bit_clear_op_i,
   input wire logic named_io_invert_op_i,
   input wire logic [2:0] out_bit_i,
   input wire logic bit_test_op_i,
   input wire logic [1:0] test_sel_i,
   input wire logic [2:0] test_bit_i,
   input wire logic [15:0] in_i,
   output logic [63:0] tmr_contact_o,
   output logic [63:0] ctr_contact_o,
   output logic [15:0] timer_present_value_o,
   output logic [15:0] present_count_o,
   output logic cusfn_run_o,
   output logic [7:0] out_o,
   output logic test_o
);
   typedef struct packed {
      logic [63:0][15:0] tmr_preset;
      logic [63:0][15:0] tmr_pv;
      logic [63:0] tmr_prev;
      logic [63:0] tmr_run;
      logic [63:0] tmr_done;
      logic [63:0][15:0] ctr_preset;
      logic [63:0][15:0] ctr_pv;
      logic [63:0] ctr_prev;
      logic [63:0] ctr_loaded;
      logic [63:0] ctr_done;
      logic [15:0] tmr_rd;
      logic [15:0] ctr_rd;
      logic fn_run;
   } ptc_st_t;

   ptc_st_t st_ff;
   ptc_st_t nxt_st;
   logic tick;

   function automatic logic [15:0] dec_sat(input logic [15:0] v);
      dec_sat = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
   endfunction

   ptc_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .tick_o(tick)
   );

   ptc_io u_io (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .run_i(st_ff.fn_run),
      .bit_set_op_i(bit_set_op_i),
      .bit_clear_op_i(bit_clear_op_i),
      .named_io_invert_op_i(named_io_invert_op_i),
      .out_bit_i(out_bit_i),
      .bit_test_op_i(bit_test_op_i),
      .test_sel_i(test_sel_i),
      .test_bit_i(test_bit_i),
      .in_i(in_i),
      .out_o(out_o),
      .test_o(test_o)
   );

   always_comb begin
      nxt_st = st_ff;
      if (scan_i) begin
         nxt_st.fn_run = cusfn_coil_i; // RULE_13
      end
      for (int i = 0; i < 64; i++) begin
         // timers: a drop or a rise wins over the tick; a held coil keeps timing
         if (scan_i) begin
            nxt_st.tmr_prev[i] = tmr_coil_i[i]; // RULE_16
         end
         if (scan_i && !tmr_coil_i[i]) begin
            nxt_st.tmr_done[i] = 1'b0; // RULE_03
            nxt_st.tmr_run[i] = 1'b0; // RULE_04
            nxt_st.tmr_pv[i] = ptc_pkg::PV_RST; // RULE_04
         end else if (scan_i && !st_ff.tmr_prev[i]) begin
            nxt_st.tmr_pv[i] = st_ff.tmr_preset[i]; // RULE_05
            nxt_st.tmr_run[i] = (st_ff.tmr_preset[i] != 16'h0000);
            nxt_st.tmr_done[i] = (st_ff.tmr_preset[i] == 16'h0000); // RULE_01
         end else if (tick && st_ff.tmr_run[i]) begin
            nxt_st.tmr_pv[i] = dec_sat(st_ff.tmr_pv[i]); // RULE_14
            if (st_ff.tmr_pv[i] <= 16'h0001) begin
               nxt_st.tmr_run[i] = 1'b0;
               nxt_st.tmr_done[i] = st_ff.tmr_prev[i]; // RULE_02
            end
         end
         // counters
         if (scan_i) begin
            nxt_st.ctr_prev[i] = ctr_coil_i[i]; // RULE_16
            if (counter_clear_function_i[i]) begin
               nxt_st.ctr_done[i] = 1'b0; // RULE_09
               nxt_st.ctr_loaded[i] = 1'b0; // RULE_17
               nxt_st.ctr_pv[i] = ptc_pkg::PV_RST; // RULE_17
            end else if (ctr_coil_i[i] && !st_ff.ctr_prev[i]) begin
               if (!st_ff.ctr_loaded[i]) begin
                  nxt_st.ctr_loaded[i] = 1'b1;
                  nxt_st.ctr_pv[i] = dec_sat(st_ff.ctr_preset[i]); // RULE_06
                  if (st_ff.ctr_preset[i] <= 16'h0001) begin
                     nxt_st.ctr_done[i] = 1'b1; // RULE_08
                  end
               end else if (st_ff.ctr_pv[i] != 16'h0000) begin
                  nxt_st.ctr_pv[i] = dec_sat(st_ff.ctr_pv[i]); // RULE_07
                  if (st_ff.ctr_pv[i] == 16'h0001) begin
                     nxt_st.ctr_done[i] = 1'b1; // RULE_08
                  end
               end
            end
         end
      end
      // program access to set values and present values
      if (tmr_preset_we_i) begin
         nxt_st.tmr_preset[idx_i] = val_i;
      end
      if (ctr_preset_we_i) begin
         nxt_st.ctr_preset[idx_i] = val_i;
      end
      if (tmr_pv_we_i) begin
         nxt_st.tmr_pv[idx_i] = val_i; // RULE_15
         nxt_st.tmr_run[idx_i] = (val_i != 16'h0000);
         nxt_st.tmr_done[idx_i] = (val_i == 16'h0000) && st_ff.tmr_prev[idx_i];
      end
      if (ctr_pv_we_i) begin
         nxt_st.ctr_pv[idx_i] = val_i; // RULE_15
         nxt_st.ctr_loaded[idx_i] = 1'b1;
         if (val_i == 16'h0000) begin
            nxt_st.ctr_done[idx_i] = 1'b1;
         end
      end
      nxt_st.tmr_rd = st_ff.tmr_pv[rd_idx_i]; // RULE_15
      nxt_st.ctr_rd = st_ff.ctr_pv[rd_idx_i]; // RULE_15
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tmr_contact_o = st_ff.tmr_done;
   assign ctr_contact_o = st_ff.ctr_done;
   assign timer_present_value_o = st_ff.tmr_rd;
   assign present_count_o = st_ff.ctr_rd;
   assign cusfn_run_o = st_ff.fn_run;

   property p_tmr_start_open;
      @(posedge clk_sys_i) disable iff (rst_i)
      scan_i && tmr_coil_i[0] && !st_ff.tmr_prev[0] && st_ff.tmr_preset[0] > 16'h0001 && !tmr_pv_we_i
      |=> !tmr_contact_o[0] [*2];
   endproperty
   a_tmr_start_open: assert property (p_tmr_start_open) else $error("timer closed before delay"); // RULE_01

   property p_tmr_hold;
      @(posedge clk_sys_i) disable iff (rst_i)
      tmr_contact_o[0] && !(scan_i && !tmr_coil_i[0]) && !tmr_pv_we_i |=> tmr_contact_o[0];
   endproperty
   a_tmr_hold: assert property (p_tmr_hold) else $error("timer contact dropped with coil on"); // RULE_02

   property p_tmr_drop;
      @(posedge clk_sys_i) disable iff (rst_i)
      scan_i && !tmr_pv_we_i |=> (tmr_contact_o & ~$past(tmr_coil_i)) == 64'h0;
   endproperty
   a_tmr_drop: assert property (p_tmr_drop) else $error("timer contact stayed after coil off"); // RULE_03

   property p_tmr_abort;
      @(posedge clk_sys_i) disable iff (rst_i)
      scan_i && !tmr_coil_i[0] && !tmr_pv_we_i |=> !st_ff.tmr_run[0] && st_ff.tmr_pv[0] == 16'h0000;
   endproperty
   a_tmr_abort: assert property (p_tmr_abort) else $error("aborted timer not reset"); // RULE_04

   property p_tmr_reload;
      @(posedge clk_sys_i) disable iff (rst_i)
      scan_i && tmr_coil_i[0] && !st_ff.tmr_prev[0] && !tmr_pv_we_i
      |=> st_ff.tmr_pv[0] == $past(st_ff.tmr_preset[0]);
   endproperty
   a_tmr_reload: assert property (p_tmr_reload) else $error("timer did not restart from preset"); // RULE_05

   property p_ctr_load;
      @(posedge clk_sys_i) disable iff (rst_i)
      scan_i && ctr_coil_i[0] && !st_ff.ctr_prev[0] && !st_ff.ctr_loaded[0]
      && !counter_clear_function_i[0] && !ctr_pv_we_i && st_ff.ctr_preset[0] != 16'h0000
      |=> st_ff.ctr_pv[0] == $past(st_ff.ctr_preset[0]) - 16'h0001;
   endproperty
   a_ctr_load: assert property (p_ctr_load) else $error("counter not loaded with preset minus one"); // RULE_06

   property p_ctr_hold_on;
      @(posedge clk_sys_i) disable iff (rst_i)
      scan_i && ctr_coil_i[0] && st_ff.ctr_prev[0] && !counter_clear_function_i[0] && !ctr_pv_we_i
      |=> $stable(st_ff.ctr_pv[0]);
   endproperty
   a_ctr_hold_on: assert property (p_ctr_hold_on) else $error("counter moved with coil held on"); // RULE_07

   property p_ctr_latch;
      @(posedge clk_sys_i) disable iff (rst_i)
      ctr_contact_o[0] && !(scan_i && counter_clear_function_i[0]) |=> ctr_contact_o[0];
   endproperty
   a_ctr_latch: assert property (p_ctr_latch) else $error("counter contact dropped without clear"); // RULE_08

   property p_ctr_clear;
      @(posedge clk_sys_i) disable iff (rst_i)
      scan_i && counter_clear_function_i[0] && !ctr_pv_we_i
      |=> !ctr_contact_o[0] && !st_ff.ctr_loaded[0];
   endproperty
   a_ctr_clear: assert property (p_ctr_clear) else $error("counter clear did not re-arm"); // RULE_09

   property p_fn_run;
      @(posedge clk_sys_i) disable iff (rst_i)
      scan_i |=> cusfn_run_o == $past(cusfn_coil_i);
   endproperty
   a_fn_run: assert property (p_fn_run) else $error("custom function run flag wrong"); // RULE_13

   property p_tmr_run_open;
      @(posedge clk_sys_i) disable iff (rst_i)
      st_ff.tmr_run[0] |-> !tmr_contact_o[0];
   endproperty
   a_tmr_run_open: assert property (p_tmr_run_open) else $error("timer contact closed while timing"); // RULE_01

   property p_tmr_expire;
      @(posedge clk_sys_i) disable iff (rst_i)
      tick && !scan_i && !tmr_pv_we_i && st_ff.tmr_run[0]
      && st_ff.tmr_pv[0] == 16'h0001 && st_ff.tmr_prev[0]
      |=> tmr_contact_o[0];
   endproperty
   a_tmr_expire: assert property (p_tmr_expire) else $error("timer contact did not close at expiry"); // RULE_02

   property p_tmr_tick;
      @(posedge clk_sys_i) disable iff (rst_i)
      tick && st_ff.tmr_run[0] && !tmr_pv_we_i && !(scan_i && !(tmr_coil_i[0] && st_ff.tmr_prev[0]))
      |=> st_ff.tmr_pv[0] == $past(st_ff.tmr_pv[0]) - 16'h0001;
   endproperty
   a_tmr_tick: assert property (p_tmr_tick) else $error("timer missed a tenth-second tick"); // RULE_14

   property p_ctr_dec;
      @(posedge clk_sys_i) disable iff (rst_i)
      scan_i && ctr_coil_i[0] && !st_ff.ctr_prev[0] && st_ff.ctr_loaded[0] && st_ff.ctr_pv[0] != 16'h0000
      && !counter_clear_function_i[0] && !ctr_pv_we_i
      |=> st_ff.ctr_pv[0] == $past(st_ff.ctr_pv[0]) - 16'h0001;
   endproperty
   a_ctr_dec: assert property (p_ctr_dec) else $error("counter did not step down on coil rise"); // RULE_07

   property p_ctr_zero;
      @(posedge clk_sys_i) disable iff (rst_i)
      scan_i && ctr_coil_i[0] && !st_ff.ctr_prev[0] && st_ff.ctr_loaded[0] && st_ff.ctr_pv[0] == 16'h0001
      && !counter_clear_function_i[0]
      |=> ctr_contact_o[0];
   endproperty
   a_ctr_zero: assert property (p_ctr_zero) else $error("counter contact not set at zero"); // RULE_08

   property p_prev_scan;
      @(posedge clk_sys_i) disable iff (rst_i)
      scan_i |=> st_ff.tmr_prev == $past(tmr_coil_i) && st_ff.ctr_prev == $past(ctr_coil_i);
   endproperty
   a_prev_scan: assert property (p_prev_scan) else $error("coil state of previous scan not kept"); // RULE_16

   property p_tmr_pv_wr;
      @(posedge clk_sys_i) disable iff (rst_i)
      tmr_pv_we_i |=> st_ff.tmr_pv[$past(idx_i)] == $past(val_i);
   endproperty
   a_tmr_pv_wr: assert property (p_tmr_pv_wr) else $error("timer present value write lost"); // RULE_15

   property p_ctr_pv_wr;
      @(posedge clk_sys_i) disable iff (rst_i)
      ctr_pv_we_i |=> st_ff.ctr_pv[$past(idx_i)] == $past(val_i);
   endproperty
   a_ctr_pv_wr: assert property (p_ctr_pv_wr) else $error("counter present value write lost"); // RULE_15

   property p_ctr_rearm;
      @(posedge clk_sys_i) disable iff (rst_i)
      scan_i && counter_clear_function_i[0] && !ctr_pv_we_i |=> st_ff.ctr_pv[0] == ptc_pkg::PV_RST;
   endproperty
   a_ctr_rearm: assert property (p_ctr_rearm) else $error("cleared counter kept its count"); // RULE_17
endmodule

// file: src/ptc_pkg.sv
/*
 * constants and types shared by the timer/counter coil block.
 * assumes a single 200 MHz clock and a scan strobe from the ladder engine.
 */
package ptc_pkg;
   localparam int unsigned N_TMR = 64;
   localparam int unsigned N_CTR = 64;
   localparam int unsigned PV_W = 16;
   localparam int unsigned IDX_W = 6;
   localparam int unsigned OUT_W = 8;
   localparam int unsigned IN_W = 16;
   localparam int unsigned BIT_W = 3;
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned PV_UNIT_MS = 100;
   localparam int unsigned PV_UNIT_CYCLES = (PV_UNIT_MS * 1000000) / CLK_PERIOD_NS;
   localparam logic [15:0] PV_RST = 16'h0000;
   localparam logic [15:0] PRESET_RST = 16'h0000;
   localparam logic [7:0] OUT_RST = 8'h00;
   localparam logic [31:0] TICK_CNT_RST = 32'h00000000;
   typedef enum logic [1:0] {
      PTC_TSEL_IN1,
      PTC_TSEL_IN2,
      PTC_TSEL_OUT1,
      PTC_TSEL_NONE
   } ptc_tsel_t;
endpackage

// file: src/ptc_tick.sv
/*
 * tenth-of-second enable divider for timer present values.
 * assumes clk_sys_i at 200 MHz; TICK_CYCLES may be shortened for simulation.
 */
`timescale 1ns/10ps
module ptc_tick #(
   parameter int unsigned TICK_CYCLES = ptc_pkg::PV_UNIT_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   output logic tick_o
);
   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } ptc_tick_st_t;

   ptc_tick_st_t st_ff;
   ptc_tick_st_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (st_ff.cnt >= 32'(TICK_CYCLES - 1)) begin
         nxt_st.cnt = ptc_pkg::TICK_CNT_RST;
         nxt_st.tick = 1'b1; // RULE_14
      end else begin
         nxt_st.cnt = st_ff.cnt + 32'h00000001;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_ff <= '{cnt: ptc_pkg::TICK_CNT_RST, tick: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick_o = st_ff.tick;

   property p_tick_single;
      @(posedge clk_sys_i) disable iff (rst_i)
      tick_o |=> !tick_o;
   endproperty
   a_tick_single: assert property (p_tick_single) else $error("tick lasted two cycles"); // RULE_14
endmodule

// file: src/ptc_io.sv
/*
 * digital output word and bit operations of the custom function.
 * assumes ops are single-cycle pulses, honoured only while run_i is high.
 */
`timescale 1ns/10ps
module ptc_io (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic bit_set_op_i,
   input wire logic bit_clear_op_i,
   input wire logic named_io_invert_op_i,
   input wire logic [2:0] out_bit_i,
   input wire logic bit_test_op_i,
   input wire logic [1:0] test_sel_i,
   input wire logic [2:0] test_bit_i,
   input wire logic [15:0] in_i,
   output logic [7:0] out_o,
   output logic test_o
);
   typedef struct packed {
      logic [7:0] outw;
      logic test;
   } ptc_io_st_t;

   ptc_io_st_t st_ff;
   ptc_io_st_t nxt_st;
   ptc_pkg::ptc_tsel_t tsel;

   always_comb begin
      nxt_st = st_ff;
      tsel = ptc_pkg::ptc_tsel_t'(test_sel_i);
      if (run_i) begin
         if (bit_set_op_i) begin
            nxt_st.outw[out_bit_i] = 1'b1; // RULE_10
         end else if (bit_clear_op_i) begin
            nxt_st.outw[out_bit_i] = 1'b0; // RULE_10
         end else if (named_io_invert_op_i) begin
            nxt_st.outw[out_bit_i] = ~st_ff.outw[out_bit_i]; // RULE_12
         end
         if (bit_test_op_i) begin
            case (tsel)
               ptc_pkg::PTC_TSEL_IN1: nxt_st.test = in_i[{1'b0, test_bit_i}];
               ptc_pkg::PTC_TSEL_IN2: nxt_st.test = in_i[{1'b1, test_bit_i}]; // RULE_11
               ptc_pkg::PTC_TSEL_OUT1: nxt_st.test = st_ff.outw[test_bit_i];
               default: nxt_st.test = 1'b0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_ff <= '{outw: ptc_pkg::OUT_RST, test: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign out_o = st_ff.outw;
   assign test_o = st_ff.test;

   property p_set_bit;
      @(posedge clk_sys_i) disable iff (rst_i)
      run_i && bit_set_op_i |=> out_o[$past(out_bit_i)];
   endproperty
   a_set_bit: assert property (p_set_bit) else $error("set did not drive output on"); // RULE_10

   property p_invert;
      @(posedge clk_sys_i) disable iff (rst_i)
      run_i && named_io_invert_op_i && !bit_set_op_i && !bit_clear_op_i
      |=> out_o[$past(out_bit_i)] != $past(out_o[out_bit_i]);
   endproperty
   a_invert: assert property (p_invert) else $error("invert did not flip output"); // RULE_12

   property p_test_in10;
      @(posedge clk_sys_i) disable iff (rst_i)
      run_i && bit_test_op_i && test_sel_i == 2'h1 && test_bit_i == 3'h1 |=> test_o == $past(in_i[9]);
   endproperty
   a_test_in10: assert property (p_test_in10) else $error("test of input 10 wrong"); // RULE_11
endmodule

// file: tb/ptc_ladder.sv
/*
 * ladder program model: issues scan strobes with coil, clear and rung levels.
 * assumes the bench calls do_scan; coil and rung levels only change with a strobe, clear drops back to zero after it.
 */
`timescale 1ns/10ps
module ptc_ladder (
   input wire logic clk_sys_i,
   output logic scan_o,
   output logic [63:0] tmr_coil_o,
   output logic [63:0] ctr_coil_o,
   output logic [63:0] clr_o,
   output logic cusfn_o
);
   int idle;
   initial begin
      scan_o = 1'b0;
      tmr_coil_o = '0;
      ctr_coil_o = '0;
      clr_o = '0;
      cusfn_o = 1'b0;
   end
   // random idle gap makes the program sometimes prompt, sometimes slow
   task automatic do_scan(input logic [63:0] tc, input logic [63:0] cc, input logic [63:0] cl, input logic cf);
      idle = $urandom_range(2);
      repeat (idle + 1) @(posedge clk_sys_i);
      #1;
      scan_o = 1'b1;
      tmr_coil_o = tc;
      ctr_coil_o = cc;
      clr_o = cl;
      cusfn_o = cf;
      @(posedge clk_sys_i);
      #1;
      scan_o = 1'b0;
      clr_o = '0;
   endtask
endmodule

// file: tb/plc_timer_counter_coils_bench.sv
/*
 * self-checking bench for ptc_core with a ladder program model.
 * assumes TICK_CYCLES of 4 and one-cycle registered answers.
 */
`timescale 1ns/10ps
module plc_timer_counter_coils_bench;
   typedef struct {int kind; int due; logic [15:0] exp;} ptc_note_t;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic scan_i, cusfn_coil_i, cusfn_run_o, test_o;
   logic [63:0] tmr_coil_i, ctr_coil_i, clr_i, tmr_contact_o, ctr_contact_o, tb, cb;
   logic [5:0] idx_i = '0;
   logic [5:0] rd_idx_i = '0;
   logic [15:0] val_i = '0;
   logic [15:0] in_i = '0;
   logic [15:0] tpv_o, present_count_o, v;
   logic tp_we = 1'b0;
   logic cp_we = 1'b0;
   logic cv_we = 1'b0;
   logic tv_we = 1'b0;
   logic set_op = 1'b0;
   logic clr_op = 1'b0;
   logic inv_op = 1'b0;
   logic tst_op = 1'b0;
   logic [2:0] obit = '0;
   logic [1:0] tsel = '0;
   logic [7:0] out_o, exp;
   int cyc = 0;
   int err_total = 0;
   int num_checks = 0;
   int t, b, i;
   ptc_note_t notes[$];
   ptc_note_t nt;
   ptc_ladder i_ptc_ladder (.clk_sys_i(clk_sys_i), .scan_o(scan_i), .tmr_coil_o(tmr_coil_i),
      .ctr_coil_o(ctr_coil_i), .clr_o(clr_i), .cusfn_o(cusfn_coil_i));
   ptc_core #(.TICK_CYCLES(4)) i_ptc_core (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scan_i(scan_i),
      .tmr_coil_i(tmr_coil_i), .ctr_coil_i(ctr_coil_i), .counter_clear_function_i(clr_i), .idx_i(idx_i),
      .val_i(val_i), .tmr_preset_we_i(tp_we), .ctr_preset_we_i(cp_we), .tmr_pv_we_i(tv_we),
      .ctr_pv_we_i(cv_we), .rd_idx_i(rd_idx_i), .cusfn_coil_i(cusfn_coil_i), .bit_set_op_i(set_op),
      .bit_clear_op_i(clr_op), .named_io_invert_op_i(inv_op), .out_bit_i(obit), .bit_test_op_i(tst_op),
      .test_sel_i(tsel), .test_bit_i(obit), .in_i(in_i), .tmr_contact_o(tmr_contact_o),
      .ctr_contact_o(ctr_contact_o), .timer_present_value_o(tpv_o), .present_count_o(present_count_o),
      .cusfn_run_o(cusfn_run_o), .out_o(out_o), .test_o(test_o));
   initial begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_total++;
         summarize();
      end
   end
   task automatic summarize();
      if (err_total == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic cmp_bit(input logic got, input logic e, input int k);
      num_checks++;
      if (got !== e) begin
         err_total++;
         $display("Error %0t: flag kind %0d is %b, wanted %b", $time, k, got, e);
      end
   endtask
   task automatic cmp_word(input logic [15:0] got, input logic [15:0] e, input int k);
      num_checks++;
      if (got !== e) begin
         err_total++;
         $display("Error %0t: word kind %0d is %h, wanted %h", $time, k, got, e);
      end
   endtask
   task automatic note(input int k, input int d, input logic [15:0] e);
      notes.push_back('{k, cyc + d, e});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   // k: 0 timer preset, 1 counter preset, 2 counter present value, 3 timer present value
   task automatic wr(input int k, input logic [5:0] ix, input logic [15:0] d);
      idx_i = ix;
      val_i = d;
      tp_we = (k == 0);
      cp_we = (k == 1);
      cv_we = (k == 2);
      tv_we = (k == 3);
      tick(1);
      tp_we = 1'b0;
      cp_we = 1'b0;
      cv_we = 1'b0;
      tv_we = 1'b0;
   endtask
   // k: 0 set, 1 clear, 2 invert, 3 test, other idle; levels stay driven until the next op call
   task automatic op(input int k, input int bt, input logic [1:0] s);
      set_op = (k == 0);
      clr_op = (k == 1);
      inv_op = (k == 2);
      tst_op = (k == 3);
      obit = bt[2:0];
      tsel = s;
      tick(1);
   endtask
   always @(negedge clk_sys_i) begin
      while (notes.size() > 0 && notes[0].due <= cyc) begin
         nt = notes.pop_front();
         case (nt.kind)
            0: cmp_bit(tmr_contact_o[t], nt.exp[0], 0);
            1: cmp_bit(ctr_contact_o[t], nt.exp[0], 1);
            2: cmp_bit(cusfn_run_o, nt.exp[0], 2);
            3: cmp_bit(test_o, nt.exp[0], 3);
            4: cmp_word({8'h00, out_o}, nt.exp, 4);
            6: cmp_word(tpv_o, nt.exp, 6);
            default: cmp_word(present_count_o, nt.exp, 5);
         endcase
      end
   end
   initial begin
      void'($urandom(34));
      tick(12);
      rst_i = 1'b0;
      t = $urandom_range(63);
      in_i = $urandom;
      // index 0 runs alongside the random one so the design's own checks see traffic
      tb = (64'h1 << t) | 64'h1;
      cb = tb;
      rd_idx_i = t;
      wr(0, t, 16'h0005);
      wr(1, t, 16'h0003);
      wr(0, 6'h00, 16'h0005);
      wr(1, 6'h00, 16'h0003);
      i_ptc_ladder.do_scan(tb, '0, '0, 1'b0);
      note(0, 16, 16'h0000);
      note(0, 22, 16'h0001);
      tick(23);
      i_ptc_ladder.do_scan(tb, '0, '0, 1'b0);
      note(0, 0, 16'h0001);
      i_ptc_ladder.do_scan('0, '0, '0, 1'b0);
      note(0, 0, 16'h0000);
      i_ptc_ladder.do_scan(tb, '0, '0, 1'b0);
      tick(8);
      i_ptc_ladder.do_scan('0, '0, '0, 1'b0);
      note(0, 12, 16'h0000);
      tick(13);
      i_ptc_ladder.do_scan(tb, '0, '0, 1'b0);
      note(0, 16, 16'h0000);
      note(0, 22, 16'h0001);
      tick(23);
      i_ptc_ladder.do_scan('0, cb, '0, 1'b0);
      note(5, 1, 16'h0002);
      i_ptc_ladder.do_scan('0, cb, '0, 1'b0);
      note(5, 1, 16'h0002);
      for (i = 1; i >= 0; i--) begin
         i_ptc_ladder.do_scan('0, '0, '0, 1'b0);
         i_ptc_ladder.do_scan('0, cb, '0, 1'b0);
         note(5, 1, i);
      end
      note(1, 2, 16'h0001);
      tick(3);
      i_ptc_ladder.do_scan('0, '0, '0, 1'b0);
      note(1, 1, 16'h0001);
      i_ptc_ladder.do_scan('0, '0, cb, 1'b0);
      note(1, 1, 16'h0000);
      tick(2);
      i_ptc_ladder.do_scan('0, cb, '0, 1'b0);
      note(5, 1, 16'h0002);
      note(1, 1, 16'h0000);
      tick(2);
      v = $urandom;
      wr(2, t ^ 6'h15, v);
      rd_idx_i = t ^ 6'h15;
      note(5, 1, v);
      v = $urandom;
      wr(3, t ^ 6'h15, v);
      note(6, 1, v);
      tick(2);
      i_ptc_ladder.do_scan('0, '0, '0, 1'b0);
      note(2, 0, 16'h0000);
      op(0, 3, 2'h0);
      note(4, 0, 16'h0000);
      op(4, 0, 2'h0);
      i_ptc_ladder.do_scan('0, '0, '0, 1'b1);
      note(2, 0, 16'h0001);
      exp = '0;
      for (i = 0; i < 8; i++) begin
         op(0, i, 2'h0);
         exp[i] = 1'b1;
         note(4, 0, {8'h00, exp});
      end
      op(1, 7, 2'h0);
      exp[7] = 1'b0;
      note(4, 0, {8'h00, exp});
      b = $urandom_range(7);
      for (i = 0; i < 2; i++) begin
         op(2, b, 2'h0);
         exp[b] = ~exp[b];
         note(4, 0, {8'h00, exp});
      end
      for (i = 0; i < 8; i++) begin
         op(3, i, 2'h1);
         note(3, 0, in_i[8 + i]);
      end
      op(3, b, 2'h2);
      note(3, 0, exp[b]);
      op(3, b, 2'h0);
      note(3, 0, in_i[b]);
      op(3, b, 2'h3);
      note(3, 0, 16'h0000);
      op(4, 0, 2'h0);
      tick(3);
      summarize();
   end
endmodule
